// ===== gsc_pkg.sv
// What this block does
// - In gated-count mode (011) the counter steps on each primary rise seen while the secondary is high.
// - In signed-count mode (101) each primary rise is counted, the secondary level picking up or down.
// - Both inputs are sampled on the timer module clock and a transition detector finds rising edges.
// - Edge logic sees at most one rise or one fall of an input in one clock period.
// - In gated-count mode a primary rise with the secondary low never counts; a secondary rise next cycle counts only if the primary is still high.
// - A primary rise is judged against the secondary level taken at the same sampling instant.
// - In gated-count mode a secondary rise while the primary is already high also counts.
// - Filter period 1 with sample count 0 gives five cycles of latency, with sample count 1 six cycles.
// - Only external sources pass the filter; internal sources bypass it and cannot be realigned.
package gsc_pkg;

    // =====================================================
    // Register map (byte addresses)
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] PFILT_ADDR  = 8'h04;
    localparam logic [7:0] SFILT_ADDR  = 8'h08;
    localparam logic [7:0] COUNT_ADDR  = 8'h0c;
    localparam logic [7:0] STATUS_ADDR = 8'h10;
    localparam logic [7:0] ID_ADDR     = 8'h14;

    // =====================================================
    // Field positions
    localparam int MODE_LSB     = 0;
    localparam int PSEL_BIT     = 4;
    localparam int SSEL_BIT     = 5;
    localparam int PER_LSB      = 0;
    localparam int SCNT_LSB     = 8;
    localparam int ST_PRIM_BIT  = 0;
    localparam int ST_SEC_BIT   = 1;
    localparam int ST_DIR_BIT   = 2;

    // =====================================================
    // Widths and reset values
    localparam int MODE_W  = 3;
    localparam int PER_W   = 8;
    localparam int SCNT_W  = 3;
    localparam int COUNT_W = 16;
    localparam logic [2:0]  MODE_RST  = 3'h0;
    localparam logic [7:0]  PER_RST   = 8'h00;
    localparam logic [2:0]  SCNT_RST  = 3'h0;
    localparam logic [15:0] COUNT_RST = 16'h0000;

    // Fixed conditioning stages ahead of the filter counter
    localparam int FILT_PIPE = 3;

    // =====================================================
    // Count modes
    typedef enum logic [2:0] {
        MODE_OFF    = 3'b000,
        MODE_RISE   = 3'b001,
        MODE_GATED  = 3'b011,
        MODE_SIGNED = 3'b101
    } gsc_mode_type;

endpackage : gsc_pkg

// ===== gsc_filter.sv
module gsc_filter (
    // Clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_n,
    // Settings
    input  wire logic [gsc_pkg::PER_W-1:0]  i_period,
    input  wire logic [gsc_pkg::SCNT_W-1:0] i_samples,
    // Signal
    input  wire logic                   i_in,
    output logic                        o_out
);

    // =====================================================
    // Fixed sampling pipeline
    logic [gsc_pkg::FILT_PIPE-1:0] pipe_reg;
    logic [gsc_pkg::PER_W-1:0]     tick_reg;
    logic [gsc_pkg::SCNT_W-1:0]    match_reg;
    logic                          state_reg;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pipe_reg <= '0;
        end else begin
            pipe_reg <= {pipe_reg[gsc_pkg::FILT_PIPE-2:0], i_in};
        end
    end

    // =====================================================
    // Sample tick every period cycles
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tick_reg <= '0;
        end else if (tick_reg >= i_period - 8'h01) begin
            tick_reg <= '0;
        end else begin
            tick_reg <= tick_reg + 8'h01;
        end
    end

    // New level needs samples+1 agreeing ticks
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            match_reg <= '0;
            state_reg <= 1'b0;
        end else if (tick_reg == '0) begin
            if (pipe_reg[gsc_pkg::FILT_PIPE-1] == state_reg) begin
                match_reg <= '0;
            end else if (match_reg == i_samples) begin
                state_reg <= pipe_reg[gsc_pkg::FILT_PIPE-1];
                match_reg <= '0;
            end else begin
                match_reg <= match_reg + 3'h1;
            end
        end
    end

    // Period zero bypasses the filter counter
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_out <= 1'b0;
        end else if (i_period == '0) begin
            o_out <= pipe_reg[0];
        end else begin
            o_out <= state_reg;
        end
    end

endmodule : gsc_filter

// ===== gsc_counter.sv
module gsc_counter #(
    // Arbitrary identification value
    parameter logic [31:0] ID_VALUE = 32'h0000_5a01
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // AHB-Lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic [31:0]      o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // Count sources
    input  wire logic        i_prim_ext,
    input  wire logic        i_sec_ext,
    input  wire logic        i_prim_int,
    input  wire logic        i_sec_int,
    // Counter state
    output logic [15:0]      o_count,
    output logic             o_count_down
);

    // =====================================================
    // Register state
    logic [2:0]  mode_reg;
    logic        psel_int_reg;
    logic        ssel_int_reg;
    logic [7:0]  pper_reg;
    logic [2:0]  pscnt_reg;
    logic [7:0]  sper_reg;
    logic [2:0]  sscnt_reg;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic        down_reg;

    // Bus data phase state
    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;
    logic        addr_ok;
    logic [31:0] rd_value;

    // Input path
    logic        prim_filt;
    logic        sec_filt;
    logic        prim_int_reg;
    logic        sec_int_reg;
    logic        prim_lvl;
    logic        sec_lvl;
    logic        prim_prev_reg;
    logic        sec_prev_reg;
    logic        prim_rise;
    logic        sec_rise;
    logic        step;
    logic        step_down;
    logic        bus_cnt_wr;

    // =====================================================
    // Bus responses: zero wait, always OKAY
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

    assign addr_ok = i_hsel && i_hready && i_htrans[1];

    // Full word only; other sizes still hit the whole word
    function automatic logic [31:0] read_mux(input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a == gsc_pkg::CTRL_ADDR) begin
            r[gsc_pkg::MODE_LSB +: gsc_pkg::MODE_W] = mode_reg;
            r[gsc_pkg::PSEL_BIT] = psel_int_reg;
            r[gsc_pkg::SSEL_BIT] = ssel_int_reg;
        end else if (a == gsc_pkg::PFILT_ADDR) begin
            r[gsc_pkg::PER_LSB +: gsc_pkg::PER_W]   = pper_reg;
            r[gsc_pkg::SCNT_LSB +: gsc_pkg::SCNT_W] = pscnt_reg;
        end else if (a == gsc_pkg::SFILT_ADDR) begin
            r[gsc_pkg::PER_LSB +: gsc_pkg::PER_W]   = sper_reg;
            r[gsc_pkg::SCNT_LSB +: gsc_pkg::SCNT_W] = sscnt_reg;
        end else if (a == gsc_pkg::COUNT_ADDR) begin
            r[gsc_pkg::COUNT_W-1:0] = count_reg;
        end else if (a == gsc_pkg::STATUS_ADDR) begin
            r[gsc_pkg::ST_PRIM_BIT] = prim_lvl;
            r[gsc_pkg::ST_SEC_BIT]  = sec_lvl;
            r[gsc_pkg::ST_DIR_BIT]  = down_reg;
        end else if (a == gsc_pkg::ID_ADDR) begin
            r = ID_VALUE;
        end
        return r;
    endfunction : read_mux

    // Process form so register changes re-run the mux
    always_comb begin
        rd_value = read_mux(i_haddr[7:0]);
    end

    // =====================================================
    // Address phase capture
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else if (i_hready) begin
            wr_pend_reg <= addr_ok && i_hwrite && (i_haddr[31:8] == '0);
            wr_addr_reg <= i_haddr[7:0];
        end
    end

    // Read data sampled at the address phase, out of a flip-flop
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_hrdata <= 32'h0000_0000;
        end else if (addr_ok && !i_hwrite) begin
            if (i_haddr[31:8] == '0) begin
                o_hrdata <= rd_value;
            end else begin
                o_hrdata <= 32'h0000_0000;
            end
        end
    end

    // =====================================================
    // Control and filter settings
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            mode_reg     <= gsc_pkg::MODE_RST;
            psel_int_reg <= 1'b0;
            ssel_int_reg <= 1'b0;
        end else if (wr_pend_reg && wr_addr_reg == gsc_pkg::CTRL_ADDR) begin
            mode_reg     <= i_hwdata[gsc_pkg::MODE_LSB +: gsc_pkg::MODE_W];
            psel_int_reg <= i_hwdata[gsc_pkg::PSEL_BIT];
            ssel_int_reg <= i_hwdata[gsc_pkg::SSEL_BIT];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pper_reg  <= gsc_pkg::PER_RST;
            pscnt_reg <= gsc_pkg::SCNT_RST;
        end else if (wr_pend_reg && wr_addr_reg == gsc_pkg::PFILT_ADDR) begin
            pper_reg  <= i_hwdata[gsc_pkg::PER_LSB +: gsc_pkg::PER_W];
            pscnt_reg <= i_hwdata[gsc_pkg::SCNT_LSB +: gsc_pkg::SCNT_W];
        end
    end

    // Secondary one sample more than primary realigns them
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sper_reg  <= gsc_pkg::PER_RST;
            sscnt_reg <= gsc_pkg::SCNT_RST;
        end else if (wr_pend_reg && wr_addr_reg == gsc_pkg::SFILT_ADDR) begin
            sper_reg  <= i_hwdata[gsc_pkg::PER_LSB +: gsc_pkg::PER_W];
            sscnt_reg <= i_hwdata[gsc_pkg::SCNT_LSB +: gsc_pkg::SCNT_W];
        end
    end

    // =====================================================
    // External inputs through the filters
    gsc_filter u_prim_filt (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .i_period  (pper_reg),
        .i_samples (pscnt_reg),
        .i_in      (i_prim_ext),
        .o_out     (prim_filt)
    );

    gsc_filter u_sec_filt (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .i_period  (sper_reg),
        .i_samples (sscnt_reg),
        .i_in      (i_sec_ext),
        .o_out     (sec_filt)
    );

    // Internal sources take one sample, no filter
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            prim_int_reg <= 1'b0;
            sec_int_reg  <= 1'b0;
        end else begin
            prim_int_reg <= i_prim_int;
            sec_int_reg  <= i_sec_int;
        end
    end

    // Internal paths cannot be realigned by filter settings
    assign prim_lvl = psel_int_reg ? prim_int_reg : prim_filt;
    assign sec_lvl  = ssel_int_reg ? sec_int_reg  : sec_filt;

    // =====================================================
    // Transition detector on sampled levels
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            prim_prev_reg <= 1'b0;
            sec_prev_reg  <= 1'b0;
        end else begin
            prim_prev_reg <= prim_lvl;
            sec_prev_reg  <= sec_lvl;
        end
    end

    // One sample per clock: one transition at most
    assign prim_rise = prim_lvl && !prim_prev_reg;
    assign sec_rise  = sec_lvl  && !sec_prev_reg;

    // =====================================================
    // Count decision
    // Edge is combinational so it meets the secondary
    // sample of the same cycle; a registered edge would
    // see next cycle's secondary and miscount.
    always_comb begin
        step      = 1'b0;
        step_down = 1'b0;
        case (gsc_pkg::gsc_mode_type'(mode_reg))
            gsc_pkg::MODE_RISE: begin
                step = prim_rise;
            end
            gsc_pkg::MODE_GATED: begin
                // Same-instant gate
                // Secondary rise under a high primary
                step = (prim_rise && sec_lvl)
                    || (sec_rise && prim_lvl && !prim_rise);
            end
            gsc_pkg::MODE_SIGNED: begin
                step      = prim_rise;
                step_down = sec_lvl;
            end
            default: begin
                step      = 1'b0;
                step_down = 1'b0;
            end
        endcase
    end

    assign bus_cnt_wr = wr_pend_reg
        && wr_addr_reg == gsc_pkg::COUNT_ADDR;

    // Software load beats a same-cycle count
    always_comb begin
        count_next = count_reg;
        if (bus_cnt_wr) begin
            count_next = i_hwdata[gsc_pkg::COUNT_W-1:0];
        end else if (step && step_down) begin
            count_next = count_reg - 16'h0001;
        end else if (step) begin
            count_next = count_reg + 16'h0001;
        end
    end

    // Synchronous counter, never clocked by the inputs
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            count_reg <= gsc_pkg::COUNT_RST;
        end else begin
            count_reg <= count_next;
        end
    end

    // Direction of the last counted edge
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            down_reg <= 1'b0;
        end else if (step) begin
            down_reg <= step_down;
        end
    end

    // =====================================================
    // Outputs
    assign o_count      = count_reg;
    assign o_count_down = down_reg;

endmodule : gsc_counter

// ===== gsc_counter_sva.sv
module gsc_counter_sva #(
    parameter logic [31:0] ID_VALUE = 32'h0000_0000
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // Bus
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    input  wire logic [31:0] o_hrdata,
    input  wire logic        o_hreadyout,
    input  wire logic        o_hresp,
    // Counter
    input  wire logic [15:0] o_count,
    input  wire logic        o_count_down
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // =====================================================
    // Helpers
    logic wr_cnt_q;
    // Write to the count register is in its data phase
    always_ff @(posedge i_clk) begin
        wr_cnt_q <= i_rst_n && i_hsel && i_hready && i_htrans[1]
                    && i_hwrite && i_haddr == 32'h0000_000c;
    end
    sequence s_read(logic [31:0] a);
        i_hsel && i_hready && i_htrans[1] && !i_hwrite && i_haddr == a;
    endsequence
    sequence s_free_step;
        !wr_cnt_q ##1 1'b1;
    endsequence
    // =====================================================
    // Assertions
    a_ready_always: assert property (o_hreadyout == 1'b1)
        else $error("hreadyout low");
    a_resp_okay: assert property (o_hresp == 1'b0)
        else $error("hresp not okay");
    a_reset_clear: assert property ($rose(i_rst_n) |->
        o_count == 16'h0000 && !o_count_down && o_hrdata == 32'h0)
        else $error("state not cleared by reset");
    a_read_id: assert property (s_read(32'h0000_0014) |=>
        o_hrdata == ID_VALUE)
        else $error("id read wrong");
    a_unmapped_zero: assert property (s_read(32'h0000_0018) |=>
        o_hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_count_write: assert property (wr_cnt_q |=>
        o_count == $past(i_hwdata[15:0]))
        else $error("count write lost");
    a_step_unit: assert property (s_free_step |->
        o_count == $past(o_count) || o_count == $past(o_count) + 16'h1
        || o_count == $past(o_count) - 16'h1)
        else $error("count moved by more than one");
    a_dir_up: assert property (s_free_step ##0
        o_count == $past(o_count) + 16'h1 |-> !o_count_down)
        else $error("up step flagged down");
    a_dir_down: assert property (s_free_step ##0
        o_count == $past(o_count) - 16'h1 |-> o_count_down)
        else $error("down step flagged up");
endmodule : gsc_counter_sva

bind gsc_counter gsc_counter_sva #(.ID_VALUE(ID_VALUE)) u_sva (.*);

// ===== gsc_src.sv
module gsc_src (
    // Clock
    input  wire logic i_clk,
    // Source levels
    output logic      o_prim_ext,
    output logic      o_sec_ext,
    output logic      o_prim_int,
    output logic      o_sec_int
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {o_prim_ext, o_sec_ext, o_prim_int, o_sec_int} = 4'h0;
    end
    // One change per clock at most, both paths alike
    task put(input logic p, input logic s);
        @(posedge i_clk);
        o_prim_ext <= p;
        o_sec_ext  <= s;
        o_prim_int <= p;
        o_sec_int  <= s;
    endtask : put
endmodule : gsc_src

// ===== gsc_counter_tb_top.sv
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    errors++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module gsc_counter_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] ID_EXP = 32'h0000_3c7e; // Arbitrary value
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        i_hsel = 1'b1;
    logic [31:0] i_haddr = 32'h0;
    logic [1:0]  i_htrans = 2'b00;
    logic        i_hwrite = 1'b0;
    logic [2:0]  i_hsize = 3'b010;
    logic [31:0] i_hwdata = 32'h0;
    logic [31:0] o_hrdata, x;
    logic        o_hreadyout, o_hresp, o_count_down;
    logic        pe, se, pi, si;
    logic [15:0] o_count;
    int          errors = 0;
    int          check_count = 0;
    logic [2:0]  md [7] = '{3'h0, 3'h1, 3'h3, 3'h3, 3'h5, 3'h5, 3'h2};
    logic        sv [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    logic [15:0] ev [7] = '{16'h1, 16'h3, 16'h3, 16'h1, 16'h3, 16'hffff,
                            16'h1};
    always #2 i_clk = ~i_clk;
    gsc_src SRC (.i_clk(i_clk), .o_prim_ext(pe), .o_sec_ext(se),
                 .o_prim_int(pi), .o_sec_int(si));
    gsc_counter #(.ID_VALUE(ID_EXP)) DUT (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
        .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
        .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
        .o_hresp(o_hresp), .i_prim_ext(pe), .i_sec_ext(se),
        .i_prim_int(pi), .i_sec_int(si), .o_count(o_count),
        .o_count_down(o_count_down));
    // =====================================================
    // Bus tasks
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge i_clk);
        i_htrans <= 2'b10;
        i_haddr  <= {24'h0, a};
        i_hwrite <= w;
        do @(posedge i_clk);
        while (o_hreadyout !== 1'b1);
        i_htrans <= 2'b00;
        i_hwdata <= wd;
        do @(posedge i_clk);
        while (o_hreadyout !== 1'b1);
        rd = o_hrdata;
    endtask : ahb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] t;
        ahb(1'b1, a, d, t);
    endtask : wr
    task automatic settle(input logic s);
        repeat (10) SRC.put(1'b0, s);
    endtask : settle
    // =====================================================
    // Closing
    task wrap_up;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        #(20000 * 4);
        errors++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        ahb(1'b0, 8'h00, 32'h0, x); `CHK("ctrl rst", 32'h0, x)
        ahb(1'b0, 8'h0c, 32'h0, x); `CHK("count rst", 32'h0, x)
        ahb(1'b0, 8'h14, 32'h0, x); `CHK("id", ID_EXP, x)
        wr(8'h18, 32'hffff_ffff);
        ahb(1'b0, 8'h18, 32'h0, x); `CHK("unmapped", 32'h0, x)
        wr(8'h0c, 32'h0000_1234);
        ahb(1'b0, 8'h0c, 32'h0, x); `CHK("count rw", 32'h1234, x)
        // Every mode, internal sources, two primary pulses
        for (int i = 0; i < 7; i++) begin
            wr(8'h00, {26'h0, 2'b11, 1'b0, md[i]});
            settle(sv[i]);
            wr(8'h0c, 32'h0000_0001);
            repeat (2) begin SRC.put(1'b1, sv[i]); SRC.put(1'b0, sv[i]); end
            settle(sv[i]);
            `CHK("mode count", ev[i], o_count)
            if (md[i] == 3'h5) begin
                `CHK("dir", sv[i], o_count_down)
                ahb(1'b0, 8'h10, 32'h0, x);
                `CHK("status", {29'h0, sv[i], sv[i], 1'b0}, x)
            end
        end
        // Gated: rise with secondary low, then secondary rise
        wr(8'h00, 32'h0000_0033);
        settle(1'b0);
        wr(8'h0c, 32'h0);
        SRC.put(1'b1, 1'b0);
        SRC.put(1'b0, 1'b1);
        settle(1'b1);
        `CHK("adjacent", 16'h0, o_count)
        settle(1'b0);
        SRC.put(1'b1, 1'b0);
        settle(1'b0);
        `CHK("sec low", 16'h0, o_count)
        repeat (3) SRC.put(1'b1, 1'b0);
        SRC.put(1'b1, 1'b1);
        repeat (4) SRC.put(1'b1, 1'b1);
        `CHK("sec rise", 16'h1, o_count)
        // External with secondary one sample behind
        wr(8'h04, 32'h0000_0001);
        wr(8'h08, 32'h0000_0101);
        wr(8'h00, 32'h0000_0003);
        settle(1'b0);
        wr(8'h0c, 32'h0);
        SRC.put(1'b1, 1'b0);
        SRC.put(1'b0, 1'b1); // Primary low before secondary rises
        settle(1'b1);
        `CHK("ext adjacent", 16'h0, o_count)
        SRC.put(1'b1, 1'b1);
        repeat (5) @(posedge i_clk);
        #1 `CHK("ext early", 16'h0, o_count)
        repeat (1) @(posedge i_clk);
        #1 `CHK("ext late", 16'h1, o_count)
        // Internal path ignores filter delay
        settle(1'b1);
        wr(8'h00, 32'h0000_0033);
        SRC.put(1'b1, 1'b1);
        repeat (3) @(posedge i_clk);
        #1 `CHK("int bypass", 16'h2, o_count)
        settle(1'b0);
        wrap_up();
    end
endmodule : gsc_counter_tb_top
